// >>> brkwire_pkg.sv
// shared constants for the broken-wire check and channel readout link
package brkwire_pkg;
  // channel organisation
  localparam int CHANNELS   = 16;
  localparam int GROUP_W    = 8;
  localparam int FRAME_BITS = 16;

  // core clock period
  localparam int CORE_PERIOD_NS = 100;

  // capacitor charge time with a light pull-up, least time, rounds up
  localparam int CHARGE_TIME_US = 3000;
  localparam int CHARGE_CYC =
    (CHARGE_TIME_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // intact-wire pulse length for a low input, rounds down
  localparam int PULSE_TIME_NS = 50500;
  localparam int PULSE_CYC     = PULSE_TIME_NS / CORE_PERIOD_NS;

  // delay from reconnection until the receiver output rises, rounds down
  localparam int RECONNECT_TIME_NS = 14000;
  localparam int RECONNECT_CYC     = RECONNECT_TIME_NS / CORE_PERIOD_NS;

  // isolating switch delay, plain default value
  localparam int SW_DELAY_NS  = 1000;
  localparam int SW_DELAY_CYC = SW_DELAY_NS / CORE_PERIOD_NS;

  // host side serial timing, in core cycles
  localparam int SCLK_HALF_CYC = 4;
  localparam int CS_SETUP_CYC  = 6;
  localparam int CS_HIGH_CYC   = 6;

  // observation window after reconnection
  localparam int WATCH_TIME_US = 200;
  localparam int WATCH_CYC     = (WATCH_TIME_US * 1000) / CORE_PERIOD_NS;
endpackage

// >>> brkwire_if.sv
// link between the input module and the host controller
`timescale 1ns/10ps
interface brkwire_if;
  logic link_clk;             // serial clock, made by the host
  logic chip_select_line_n;   // frame select, active low
  logic ground_break_control; // high keeps the field ground connected
  logic host_data_out;        // host serial data out, unused by the module
  logic chain_serial_out;     // chain serial output toward the host

  modport device (
    input  link_clk,
    input  chip_select_line_n,
    input  ground_break_control,
    input  host_data_out,
    output chain_serial_out
  );

  modport host (
    output link_clk,
    output chip_select_line_n,
    output ground_break_control,
    output host_data_out,
    input  chain_serial_out
  );
endinterface

// >>> brkwire_device.sv
// input module end: receiver channel behaviour, parallel outputs, serial chain
`timescale 1ns/10ps
module brkwire_device #(
  parameter int CHARGE_CYC = brkwire_pkg::CHARGE_CYC, // capacitor charge cycles
  parameter int GROUP_W    = brkwire_pkg::GROUP_W     // channels per group
) (
  input  wire logic                   CORE_CLK_IN,   // core clock
  input  wire logic                   RST_IN,        // async reset, active high
  brkwire_if.device                   LINK,          // link to the host
  input  wire logic [2*GROUP_W-1:0]   FIELD_HIGH_IN, // field input level per channel
  input  wire logic [2*GROUP_W-1:0]   WIRE_OK_IN,    // wire intact per channel
  output logic      [GROUP_W-1:0]     GROUP_LO_OUT,  // parallel channels 1-8
  output logic      [GROUP_W-1:0]     GROUP_HI_OUT   // parallel channels 9-16
);
  localparam int NCH   = 2 * GROUP_W;
  localparam int SW    = $clog2(brkwire_pkg::SW_DELAY_CYC + 1);
  localparam int BW    = $clog2(brkwire_pkg::FRAME_BITS + 1);

  logic [1:0]     gbc_sync;    // ground break control synchroniser
  logic [1:0]     cs_sync;     // chip select synchroniser
  logic [NCH-1:0] field_s1;
  logic [NCH-1:0] field_s2;
  logic [NCH-1:0] wire_s1;
  logic [NCH-1:0] wire_s2;
  logic           sw_closed;   // switch state after its delay
  logic           sw_closed_q;
  logic [SW-1:0]  sw_cnt;
  logic           reconnect;
  logic [NCH-1:0] ch_state;    // receiver outputs
  logic [NCH-1:0] snap;        // shifter parallel stages
  logic [BW-1:0]  bit_cnt;     // link-domain shift position
  logic           shift_load_select;
  logic [NCH-1:0] chain_order;

  // pin inputs pass two flip-flops; reset values match a closed switch
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      gbc_sync <= 2'h3;
      cs_sync  <= 2'h3;
      field_s1 <= '0;
      field_s2 <= '0;
      wire_s1  <= '0;
      wire_s2  <= '0;
    end else begin
      gbc_sync <= {gbc_sync[0], LINK.ground_break_control};
      cs_sync  <= {cs_sync[0], LINK.chip_select_line_n};
      field_s1 <= FIELD_HIGH_IN;
      field_s2 <= field_s1;
      wire_s1  <= WIRE_OK_IN;
      wire_s2  <= wire_s1;
    end
  end

  // switch follows the control line after its own delay, both directions
  // closed by default
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sw_closed   <= 1'b1;
      sw_closed_q <= 1'b1;
      sw_cnt      <= '0;
    end else begin
      sw_closed_q <= sw_closed;
      if (gbc_sync[1] == sw_closed) begin
        sw_cnt <= '0;
      end else if (sw_cnt == SW'(brkwire_pkg::SW_DELAY_CYC - 1)) begin
        sw_closed <= gbc_sync[1];
        sw_cnt    <= '0;
      end else begin
        sw_cnt <= sw_cnt + SW'(1);
      end
    end
  end

  assign reconnect = sw_closed & ~sw_closed_q;

  // one receiver per channel, all sharing the one ground switch
  // sixteen channel receivers
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      chan_receiver #(
        .CHARGE_CYC(CHARGE_CYC)
      ) chan_receiver_inst (
        .CORE_CLK_IN (CORE_CLK_IN),
        .RST_IN      (RST_IN),
        .wire_ok_in  (wire_s2[ch]),
        .field_in    (field_s2[ch]),
        .closed_in   (sw_closed),
        .reconnect_in(reconnect),
        .level_out   (ch_state[ch])
      );
    end
  endgenerate

  // parallel readout straight from the receiver flops
  // two parallel groups
  assign GROUP_LO_OUT = ch_state[GROUP_W-1:0];
  assign GROUP_HI_OUT = ch_state[NCH-1:GROUP_W];

  // inverted chip select is the shifters' shift/load select
  // inverted chip select
  assign shift_load_select = ~LINK.chip_select_line_n;

  // stages load while select is low and hold once it rises; the hold
  // starts after the two-flop delay, so the host waits before clocking
  // continuous load
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      snap <= '0;
    end else if (cs_sync[1]) begin
      snap <= ch_state;
    end
  end

  // shift position; chip select high ends the frame, since the link
  // clock stands still between frames
  // sixteen shift clocks
  always_ff @(posedge LINK.link_clk or posedge RST_IN
              or posedge LINK.chip_select_line_n) begin
    if (RST_IN || LINK.chip_select_line_n) begin
      bit_cnt <= '0;
    end else if (shift_load_select && bit_cnt != BW'(brkwire_pkg::FRAME_BITS)) begin
      bit_cnt <= bit_cnt + BW'(1);
    end
  end

  // high group stages H..A first, then the low group through its chain
  // input; the low group's own serial input is tied low
  // low group feeds high group
  assign chain_order = {snap[GROUP_W-1:0], snap[NCH-1:GROUP_W]};
  assign LINK.chain_serial_out =
    (bit_cnt >= BW'(brkwire_pkg::FRAME_BITS)) ? 1'b0 : chain_order[bit_cnt[BW-2:0]];
endmodule

// one receiver channel; the input capacitor is a charge counter and the
// decaying pulse a fixed count, so pull-up strength is not modelled
module chan_receiver #(
  parameter int CHARGE_CYC = brkwire_pkg::CHARGE_CYC // capacitor charge cycles
) (
  input  wire logic CORE_CLK_IN,  // core clock
  input  wire logic RST_IN,       // async reset, active high
  input  wire logic wire_ok_in,   // wire intact, synchronised
  input  wire logic field_in,     // field level, synchronised
  input  wire logic closed_in,    // switch closed after its delay
  input  wire logic reconnect_in, // first cycle of a closed switch
  output logic      level_out     // receiver output
);
  localparam int CW   = $clog2(CHARGE_CYC + 1);
  localparam int PEND = brkwire_pkg::RECONNECT_CYC + brkwire_pkg::PULSE_CYC;
  localparam int PW   = $clog2(PEND + 1);

  logic [CW-1:0] charge_cnt; // capacitor charge level
  logic          charged;
  logic [PW-1:0] pulse_cnt;  // cycles since reconnection, zero when idle
  logic          pulse_act;

  assign charged   = (charge_cnt == CW'(CHARGE_CYC));
  assign pulse_act = (pulse_cnt > PW'(brkwire_pkg::RECONNECT_CYC));

  // capacitor charges only through an intact wire while ground is open
  // charge needs full open time
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      charge_cnt <= '0;
    end else if (!wire_ok_in || reconnect_in) begin
      charge_cnt <= '0;
    end else if (!closed_in && !charged) begin
      charge_cnt <= charge_cnt + CW'(1);
    end
  end

  // after reconnection a charged capacitor powers one short pulse
  // single pulse after reconnection
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pulse_cnt <= '0;
    end else if (!wire_ok_in || !closed_in) begin
      pulse_cnt <= '0;
    end else if (reconnect_in && charged && !field_in) begin
      pulse_cnt <= PW'(1);
    end else if (pulse_cnt != '0 && pulse_cnt != PW'(PEND)) begin
      pulse_cnt <= pulse_cnt + PW'(1);
    end else begin
      pulse_cnt <= '0;
    end
  end

  // output needs ground and a wire; a broken wire forces it low
  // follows switch state
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      level_out <= 1'b0;
    end else begin
      level_out <= wire_ok_in & closed_in & (field_in | pulse_act);
    end
  end
endmodule

// >>> brkwire_host.sv
// host controller end: serial readout frames and the broken-wire check
`timescale 1ns/10ps
module brkwire_host #(
  parameter int OPEN_CYC  = brkwire_pkg::CHARGE_CYC, // switch open time, cycles
  parameter int WATCH_CYC = brkwire_pkg::WATCH_CYC   // post-reconnection window
) (
  input  wire logic        CORE_CLK_IN,    // core clock
  input  wire logic        RST_IN,         // async reset, active high
  brkwire_if.host          LINK,           // link to the module
  input  wire logic        START_READ_IN,  // one-cycle read request
  input  wire logic        START_CHECK_IN, // one-cycle check request
  output logic      [15:0] READ_DATA_OUT,  // channels 16..1, bit 0 = channel 1
  output logic             READ_DONE_OUT,  // one-cycle frame done
  output logic      [15:0] BROKEN_OUT,     // broken wire flag per channel
  output logic             CHECK_DONE_OUT, // one-cycle check done
  output logic             BUSY_OUT        // high while not idle
);
  localparam int TW = $clog2(OPEN_CYC + brkwire_pkg::CS_HIGH_CYC + 1);
  localparam int WW = $clog2(WATCH_CYC + 1);

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_SETUP = 5'h02,
    S_SHIFT = 5'h04,
    S_END   = 5'h08,
    S_OPEN  = 5'h10
  } state_e;

  state_e      state;
  logic [TW-1:0] tmr;
  logic [3:0]  bit_idx;
  logic [15:0] rx;
  logic [15:0] frame;
  logic [1:0]  so_sync;
  logic        checking;
  logic [WW-1:0] watch_cnt;
  logic [15:0] seen;

  // received order is 9..16 then 1..8
  assign frame    = {rx[7:0], rx[15:8]};
  assign BUSY_OUT = (state != S_IDLE);
  assign LINK.host_data_out = 1'b0;

  // chain output is a pin from the other domain
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      so_sync <= 2'h0;
    end else begin
      so_sync <= {so_sync[0], LINK.chain_serial_out};
    end
  end

  // frame sequencing, serial clock divider and the check sequence
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state                     <= S_IDLE;
      tmr                       <= '0;
      bit_idx                   <= '0;
      rx                        <= '0;
      LINK.chip_select_line_n   <= 1'b1;
      LINK.link_clk             <= 1'b0;
      LINK.ground_break_control <= 1'b1;
    end else begin
      case (state)
        S_IDLE: begin
          tmr <= '0;
          if (START_CHECK_IN) begin
            LINK.ground_break_control <= 1'b0;
            state                     <= S_OPEN;
          end else if (START_READ_IN) begin
            LINK.chip_select_line_n <= 1'b0;
            state                   <= S_SETUP;
          end
        end
        S_OPEN: begin
          // hold open for the charge time
          if (tmr == TW'(OPEN_CYC - 1)) begin
            tmr                       <= '0;
            LINK.ground_break_control <= 1'b1;
            LINK.chip_select_line_n   <= 1'b0;
            state                     <= S_SETUP;
          end else begin
            tmr <= tmr + TW'(1);
          end
        end
        S_SETUP: begin
          // let the module freeze its stages first
          if (tmr == TW'(brkwire_pkg::CS_SETUP_CYC - 1)) begin
            tmr     <= '0;
            bit_idx <= '0;
            state   <= S_SHIFT;
          end else begin
            tmr <= tmr + TW'(1);
          end
        end
        S_SHIFT: begin
          // slow clock keeps sampling well inside limits
          if (tmr == TW'(brkwire_pkg::SCLK_HALF_CYC - 1)) begin
            tmr <= '0;
            if (!LINK.link_clk) begin
              rx[bit_idx]   <= so_sync[1];
              LINK.link_clk <= 1'b1;
            end else begin
              LINK.link_clk <= 1'b0;
              bit_idx       <= bit_idx + 4'h1;
              if (bit_idx == 4'hF) begin
                LINK.chip_select_line_n <= 1'b1;
                state                   <= S_END;
              end
            end
          end else begin
            tmr <= tmr + TW'(1);
          end
        end
        S_END: begin
          // select stays high long enough for the module to reload
          if (tmr == TW'(brkwire_pkg::CS_HIGH_CYC - 1)) begin
            tmr <= '0;
            if (checking && watch_cnt != '0) begin
              LINK.chip_select_line_n <= 1'b0;
              state                   <= S_SETUP;
            end else begin
              state <= S_IDLE;
            end
          end else begin
            tmr <= tmr + TW'(1);
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // check window and per-channel verdicts
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      checking       <= 1'b0;
      watch_cnt      <= '0;
      seen           <= '0;
      READ_DATA_OUT  <= '0;
      READ_DONE_OUT  <= 1'b0;
      BROKEN_OUT     <= '0;
      CHECK_DONE_OUT <= 1'b0;
    end else begin
      READ_DONE_OUT  <= 1'b0;
      CHECK_DONE_OUT <= 1'b0;
      if (state == S_OPEN && tmr == TW'(OPEN_CYC - 1)) begin
        checking  <= 1'b1;
        watch_cnt <= WW'(WATCH_CYC);
        seen      <= '0;
      end else if (checking && watch_cnt != '0) begin
        watch_cnt <= watch_cnt - WW'(1);
      end
      if (state == S_END && tmr == '0) begin
        READ_DATA_OUT <= frame;
        READ_DONE_OUT <= 1'b1;
        // any high marks the wire intact
        seen <= seen | frame;
        if (checking && watch_cnt == '0) begin
          BROKEN_OUT     <= ~(seen | frame);
          CHECK_DONE_OUT <= 1'b1;
          checking       <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> README_unused.sv
// spare source unit, holds no logic
`timescale 1ns/10ps

// >>> brkwire_checker.sv
// checker of the link signals between the host end and the input module end
`timescale 1ns/10ps
module brkwire_checker #(
  parameter int OPEN_CYC = brkwire_pkg::CHARGE_CYC // switch open time, cycles
) (
  input wire logic CORE_CLK_IN,          // core clock
  input wire logic RST_IN,               // async reset, active high
  input wire logic link_clk,             // serial clock from the host
  input wire logic chip_select_line_n,   // frame select, active low
  input wire logic ground_break_control, // high keeps ground connected
  input wire logic host_data_out,        // host serial data out
  input wire logic chain_serial_out      // chain output toward the host
);
  int   lo_cnt;   // cycles with the switch commanded open
  int   rise_cnt; // link clock rises in the current frame
  logic clk_q;    // link clock one core cycle back

  // open time counter, cleared whenever the ground is connected
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) lo_cnt <= 0;
    else lo_cnt <= ground_break_control ? 0 : lo_cnt + 1;
  end

  // rises are counted in the core domain; the host makes both from one clock
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      clk_q    <= 1'b0;
      rise_cnt <= 0;
    end else begin
      clk_q    <= link_clk;
      rise_cnt <= chip_select_line_n ? 0 : rise_cnt + int'(link_clk & ~clk_q);
    end
  end

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  a_reset_idle: assert property ($fell(RST_IN) |-> ground_break_control
    && chip_select_line_n && !link_clk) else $error("link not idle after reset");
  a_clk_still: assert property (chip_select_line_n |-> !link_clk)
    else $error("serial clock runs outside a frame");
  a_data_unused: assert property (!host_data_out)
    else $error("host data output driven");
  a_high_half: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk)
    else $error("serial clock high half not four cycles");
  a_cs_setup: assert property ($fell(chip_select_line_n) |-> !link_clk [*6])
    else $error("serial clock too soon after select");
  a_open_time: assert property ($rose(ground_break_control) && !$past(RST_IN)
    |-> lo_cnt == OPEN_CYC) else $error("switch open time wrong");
  a_read_after: assert property ($rose(ground_break_control)
    |-> ##[0:3] !chip_select_line_n) else $error("no prompt read after reconnect");
  a_no_read_open: assert property (!ground_break_control |-> chip_select_line_n)
    else $error("frame while switch open");
  a_sixteen_clk: assert property ($rose(chip_select_line_n) && !$past(RST_IN)
    |-> rise_cnt == 16) else $error("frame not sixteen clocks");
  a_bit_held: assert property ($fell(link_clk) && !chip_select_line_n
    |=> $stable(chain_serial_out) [*3]) else $error("chain bit moved in low half");

  // main scenarios: check, frame end, reset release
  c_check: cover property ($rose(ground_break_control));
  c_frame: cover property ($rose(chip_select_line_n));
  c_reset: cover property ($fell(RST_IN));
endmodule

// >>> tb_top.sv
// testbench joining host end and input module end across the link
`timescale 1ns/10ps
module tb_top;
  localparam int OPEN = 80; // shortened switch open time
  logic        clk;         // core clock
  logic        rst;         // reset, active high
  logic [15:0] field;       // field levels, bit 0 = channel 1
  logic [15:0] wire_ok;     // intact wires
  logic        start_rd;    // read request
  logic        start_ck;    // check request
  logic [7:0]  grp_lo;      // parallel channels 1-8
  logic [7:0]  grp_hi;      // parallel channels 9-16
  logic [15:0] rd_data;     // frame result
  logic        rd_done;     // frame done
  logic [15:0] broken;      // broken flags
  logic        ck_done;     // check done
  logic        busy;        // host busy
  logic [15:0] seen;        // channel highs gathered while waiting
  int          n_mismatch;  // mismatches
  int          total_checks; // comparisons

  brkwire_if brkwire_if_inst ();
  brkwire_device #(.CHARGE_CYC(50), .GROUP_W(8)) brkwire_device_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .LINK(brkwire_if_inst), .FIELD_HIGH_IN(field),
    .WIRE_OK_IN(wire_ok), .GROUP_LO_OUT(grp_lo), .GROUP_HI_OUT(grp_hi));
  brkwire_host #(.OPEN_CYC(OPEN), .WATCH_CYC(800)) brkwire_host_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .LINK(brkwire_if_inst), .START_READ_IN(start_rd),
    .START_CHECK_IN(start_ck), .READ_DATA_OUT(rd_data), .READ_DONE_OUT(rd_done),
    .BROKEN_OUT(broken), .CHECK_DONE_OUT(ck_done), .BUSY_OUT(busy));
  brkwire_checker #(.OPEN_CYC(OPEN)) brkwire_checker_inst (
    .CORE_CLK_IN(clk), .RST_IN(rst), .link_clk(brkwire_if_inst.link_clk),
    .chip_select_line_n(brkwire_if_inst.chip_select_line_n),
    .ground_break_control(brkwire_if_inst.ground_break_control),
    .host_data_out(brkwire_if_inst.host_data_out),
    .chain_serial_out(brkwire_if_inst.chain_serial_out));

  // core clock, 100 ns period
  always #50 clk = ~clk;

  task finish_test;
    $display("mismatches %0d of %0d checks", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // bounded wait at falling edges; also gathers every channel high seen
  task wait_for(input int which, input int lim, output int cyc);
    logic hit;
    cyc = 0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge clk);
      cyc++;
      seen |= {grp_hi, grp_lo};
      case (which)
        0: hit = (rd_done === 1'b1);
        1: hit = (ck_done === 1'b1);
        default: hit = (busy === 1'b0);
      endcase
      if (cyc > lim) begin
        n_mismatch++;
        $display("wrong value at %0t: wait ran out", $time);
        finish_test();
      end
    end
  endtask

  // one-cycle request, raised and dropped at falling edges
  task pulse(input logic ck);
    @(negedge clk);
    start_ck = ck;
    start_rd = !ck;
    @(negedge clk);
    start_ck = 1'b0;
    start_rd = 1'b0;
  endtask

  // idle link and host after any reset
  task t_idle;
    chk({13'h0000, brkwire_if_inst.chip_select_line_n, brkwire_if_inst.ground_break_control,
         brkwire_if_inst.link_clk}, 16'h0006, "link idle");
    chk(broken, 16'h0000, "flags after reset");
    chk({15'h0000, busy}, 16'h0000, "busy after reset");
  endtask

  // frame read; the field changes and a refused request arrive mid-frame
  task t_read(input logic [15:0] p);
    int c;
    field = p;
    repeat (8) @(negedge clk);
    chk({grp_hi, grp_lo}, p, "parallel outputs");
    pulse(1'b0);
    repeat (20) @(negedge clk);
    field = ~p;
    start_rd = 1'b1;
    @(negedge clk);
    start_rd = 1'b0;
    wait_for(0, 300, c);
    chk(rd_data, p, "frozen frame data");
    chk({15'h0000, (c + 22 >= 134) && (c + 22 <= 138)}, 16'h0001, "frame latency");
    wait_for(2, 20, c);
    repeat (20) @(negedge clk);
    chk({15'h0000, busy}, 16'h0000, "refused request stays refused");
  endtask

  // wire check over mixed intact and broken channels
  task t_check;
    int c;
    field = 16'h0F0F;
    wire_ok = 16'h33CC;
    repeat (8) @(negedge clk);
    pulse(1'b1);
    repeat (40) @(negedge clk);
    chk({grp_hi, grp_lo}, 16'h0000, "outputs low while open");
    seen = 16'h0000;
    wait_for(1, 3000, c);
    chk(seen, wire_ok, "highs after reconnect");
    chk(broken, ~wire_ok, "broken flags");
    chk({grp_hi, grp_lo}, field & wire_ok, "outputs back");
    wait_for(2, 20, c);
    wire_ok = 16'hFFFF;
  endtask

  // reset in the middle of a frame
  task t_reset_mid;
    pulse(1'b0);
    repeat (30) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
  endtask

  initial begin
    logic [15:0] pats [4];
    pats = '{16'hA55A, 16'h00FF, 16'h8001, 16'hFFFF};
    clk = 1'b0;
    rst = 1'b1;
    field = 16'h0000;
    wire_ok = 16'hFFFF;
    start_rd = 1'b0;
    start_ck = 1'b0;
    seen = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_idle();
    foreach (pats[i]) t_read(pats[i]);
    t_check();
    t_reset_mid();
    t_read(16'h1234);
    finish_test();
  end
endmodule
